// file: hw/nv_cfg.svh
`ifndef NV_CFG_SVH
`define NV_CFG_SVH

// register select codes on the special function register port
`define NV_SEL_TP_UPPER 4'h0
`define NV_SEL_TP_HIGH 4'h1
`define NV_SEL_TP_LOW 4'h2
`define NV_SEL_TLATCH 4'h3
`define NV_SEL_KEY 4'h4
`define NV_SEL_CTRL 4'h5
`define NV_SEL_PRIO2 4'h6
`define NV_SEL_FLAGS2 4'h7
`define NV_SEL_ENAB2 4'h8
`define NV_SEL_ADDR_LO 4'h9
`define NV_SEL_ADDR_HI 4'ha
`define NV_SEL_DATA 4'hb

// control register bit positions
`define NV_CTL_MEM 7
`define NV_CTL_CFG 6
`define NV_CTL_FREE 4
`define NV_CTL_ABORT 3
`define NV_CTL_WRITE_PERMIT 2
`define NV_CTL_WR 1
`define NV_CTL_RD 0

// write-done bit inside the second peripheral flag/enable/priority registers
`define NV_DONE_BIT 4

// unlock key bytes
`define NV_KEY_FIRST 8'h55
`define NV_KEY_SECOND 8'haa

// sizes of the data array and width of the table pointer
`define NV_ADDR_W 10
`define NV_DEPTH 1024
`define NV_TP_W 22

// reset value and erased-byte value
`define NV_RST_BYTE 8'h00
`define NV_ERASED_BYTE 8'hff

// self-timed programming: time in ns, clock period in ns
`define NV_PROG_TIME_NS 4000000
`define NV_CLK_PERIOD_NS 10

`endif

// file: hw/nv_pkg.sv
package nv_pkg;

    // programming sequencer, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ERASE = 3'b010,
        ST_PROG = 3'b100
    } wstate_t;

    // unlock key tracker, one-hot
    typedef enum logic [2:0] {
        KEY_IDLE = 3'b001,
        KEY_HALF = 3'b010,
        KEY_ARMED = 3'b100
    } key_t;

    // complete state of the access controller
    typedef struct packed {
        logic sel_mem;
        logic sel_cfg;
        logic free;
        logic abort;
        logic write_permit;
        logic wr;
        logic rd;
        logic [7:0] addr_lo;
        logic [1:0] addr_hi;
        logic [7:0] data;
        logic [21:0] tptr;
        logic [7:0] tlatch;
        logic done_flag;
        logic done_en;
        logic done_pri;
        logic irq;
        key_t key;
        wstate_t st;
        logic [31:0] tmr;
        logic [7:0] rdata;
        logic [2:0] pin_sync;
        logic pin_lvl;
    } nv_state_t;

endpackage

// file: hw/nv_byte_mem.sv
`timescale 1ns/1ps
`include "nv_cfg.svh"

module nv_byte_mem (
    input wire logic clk, // system clock
    input wire logic we, // write strobe
    input wire logic [`NV_ADDR_W-1:0] addr, // byte address
    input wire logic [7:0] wdata, // byte to store
    output logic [7:0] rdata // registered read byte
);
    logic [7:0] mem [0:`NV_DEPTH-1];

    // no reset on the array: contents are nonvolatile by intent
    always_ff @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end
endmodule

// file: hw/nv_memory_access_control.sv
`timescale 1ns/1ps
`include "nv_cfg.svh"

// How it works
// - pin or watchdog reset during a self-timed write leaves the abort flag set.
// - flash writes and erases also need the unlock key sequence first.
// - eeprom is byte wide; one data register, address held in two registers.
// - eeprom byte write erases the location, then programs it.
// - an internal timer sets write length; hardware signals completion.
// - low address picks 256 bytes; two high bits extend to 1024.
// - control bit 7 clear selects eeprom, set selects program flash.
// - control bit 6 set targets configuration space, else bit 7 decides.
// - writes and erases only while write-permit is set; cleared at power-up.
// - abort flag set on launch, cleared when the write finishes normally.
// - abort flag also reads one after an improper write attempt.
// - write-launch is set-only by software; hardware clears it on completion.
// - completion sets the write-done flag; software clears it.
// - read-launch cannot be set while either select bit is one.
// - read-launch finishes in one cycle, then hardware clears it.
// - unlock key port stores nothing and reads as zero.
// - row-erase bit makes a flash launch an erase; completion of that erase clears it.
// - an abort keeps both select bits unchanged for tracing.
// - control bit 5 is unimplemented, reads zero, ignores writes.
// - at power-up the control bits start cleared.
// - table pointer is 22 bits over upper, high and low byte registers.
// - write starts only after 55h, then aah, then the launch bit, every byte.
// - launch needs permit already set; both cannot be set in one write.
// - while writing, control, address and data registers ignore writes.
// - read data lands in the data register next cycle and holds.

module nv_memory_access_control #(
    parameter int unsigned PROG_CYCLES = `NV_PROG_TIME_NS / `NV_CLK_PERIOD_NS
) (
    input wire logic clk, // 100 MHz system clock
    input wire logic rstn, // power-on reset, async, active low
    input wire logic pin_reset, // external reset pin event, same clock
    input wire logic wdog_reset, // watchdog time-out reset, same clock
    input wire logic [3:0] sfr_sel, // register select
    input wire logic sfr_wr, // register write strobe
    input wire logic sfr_rd, // register read strobe
    input wire logic [7:0] sfr_wdata, // register write data
    output logic [7:0] sfr_rdata, // read data, one cycle after sfr_rd
    output logic prog_busy, // self-timed operation running
    output logic prog_flash, // running operation targets program flash
    output logic prog_cfg, // running operation targets configuration space
    output logic prog_erase, // running operation is in its erase phase
    output logic [21:0] table_ptr, // table pointer for flash operations
    output logic [7:0] table_data, // table latch for flash writes
    output logic done_irq, // write-done flag gated by its enable
    output logic done_high_prio // priority of the write-done request
);
    // phase lengths; eeprom splits the time between erase and program,
    // and every phase lasts at least one cycle even for a tiny PROG_CYCLES
    localparam int unsigned ERASE_CYCLES = (PROG_CYCLES / 2 > 0) ? PROG_CYCLES / 2 : 1;
    localparam int unsigned WRITE_CYCLES = (PROG_CYCLES > ERASE_CYCLES) ?
        PROG_CYCLES - ERASE_CYCLES : 1;
    localparam logic [31:0] ERASE_LAST = 32'(ERASE_CYCLES - 1);
    localparam logic [31:0] WRITE_LAST = 32'(WRITE_CYCLES - 1);
    localparam logic [31:0] FULL_LAST = 32'(PROG_CYCLES - 1);

    // registered state and its next value
    nv_pkg::nv_state_t q;
    nv_pkg::nv_state_t d;

    // helper terms shared by the processes below;
    // none but mem_rdata, the array's registered output, holds state; controller state lives in q
    logic mem_we;
    logic [7:0] mem_wdata;
    logic [7:0] mem_rdata;
    logic [`NV_ADDR_W-1:0] mem_addr;
    logic busy;
    logic eeprom_sel;
    logic warm_reset;
    logic ctl_write;
    logic launch_req;
    logic last_tick;
    logic pin_agree;
    logic pin_now;
    logic key_armed;
    logic erase_first;

    // eeprom array, read data registered
    // address and data are locked while a write runs, so the array sees them stable
    nv_byte_mem u_mem (
        .clk(clk),
        .we(mem_we),
        .addr(mem_addr),
        .wdata(mem_wdata),
        .rdata(mem_rdata)
    );

    // status terms shared by the next-state logic
    assign busy = (q.st != nv_pkg::ST_IDLE);
    assign eeprom_sel = !q.sel_mem && !q.sel_cfg;
    assign mem_addr = {q.addr_hi, q.addr_lo};
    assign warm_reset = pin_now || wdog_reset;
    assign ctl_write = sfr_wr && (sfr_sel == `NV_SEL_CTRL);
    assign launch_req = ctl_write && sfr_wdata[`NV_CTL_WR];

    // launch terms: key state, and whether the write opens with an erase
    assign key_armed = (q.key == nv_pkg::KEY_ARMED);
    assign erase_first = eeprom_sel
        || (q.sel_mem && !q.sel_cfg && sfr_wdata[`NV_CTL_FREE]);

    // external reset pin: three flops, a change counts once stages two and
    // three agree; costs three cycles but a one-cycle glitch is dropped
    assign pin_agree = (q.pin_sync[1] == q.pin_sync[2]);
    always_comb begin
        pin_now = q.pin_lvl;
        if (pin_agree) begin
            pin_now = q.pin_sync[2];
        end
    end

    // phase end: eeprom splits the timer between erase and program
    // flash and configuration run one phase of the full length
    always_comb begin
        last_tick = 1'b0;
        if (q.st == nv_pkg::ST_ERASE) begin
            last_tick = eeprom_sel ? (q.tmr == ERASE_LAST) : (q.tmr == FULL_LAST);
        end else if (q.st == nv_pkg::ST_PROG) begin
            last_tick = eeprom_sel ? (q.tmr == WRITE_LAST) : (q.tmr == FULL_LAST);
        end
    end

    // next state of every register
    always_comb begin
        d = q;
        mem_we = 1'b0;
        mem_wdata = `NV_ERASED_BYTE;

        // pin synchroniser shifts every cycle; the filtered level is kept
        d.pin_sync = {q.pin_sync[1:0], pin_reset};
        d.pin_lvl = pin_now;

        // read launch lives one cycle; array data is valid now
        // the array output is a flop, so the byte arrives one edge after rd
        if (q.rd) begin
            d.data = mem_rdata;
            d.rd = 1'b0;
        end

        // register writes from the core
        // table pointer and latch stay writable while busy; no eeprom cycle uses them
        if (sfr_wr) begin
            if (sfr_sel == `NV_SEL_TP_UPPER) begin
                d.tptr[21:16] = sfr_wdata[5:0];
            end else if (sfr_sel == `NV_SEL_TP_HIGH) begin
                d.tptr[15:8] = sfr_wdata;
            end else if (sfr_sel == `NV_SEL_TP_LOW) begin
                d.tptr[7:0] = sfr_wdata;
            end else if (sfr_sel == `NV_SEL_TLATCH) begin
                d.tlatch = sfr_wdata;
            end else if (sfr_sel == `NV_SEL_PRIO2) begin
                d.done_pri = sfr_wdata[`NV_DONE_BIT];
            end else if (sfr_sel == `NV_SEL_FLAGS2) begin
                d.done_flag = sfr_wdata[`NV_DONE_BIT];
            end else if (sfr_sel == `NV_SEL_ENAB2) begin
                d.done_en = sfr_wdata[`NV_DONE_BIT];
            end else if (sfr_sel == `NV_SEL_ADDR_LO && !busy) begin
                d.addr_lo = sfr_wdata;
            end else if (sfr_sel == `NV_SEL_ADDR_HI && !busy) begin
                d.addr_hi = sfr_wdata[1:0];
            end else if (sfr_sel == `NV_SEL_DATA && !busy) begin
                d.data = sfr_wdata;
            end else if (ctl_write && !busy) begin
                // bit 5 has no storage, wr and rd are set-only
                d.sel_mem = sfr_wdata[`NV_CTL_MEM];
                d.sel_cfg = sfr_wdata[`NV_CTL_CFG];
                d.free = sfr_wdata[`NV_CTL_FREE];
                d.abort = sfr_wdata[`NV_CTL_ABORT];
                d.write_permit = sfr_wdata[`NV_CTL_WRITE_PERMIT];
            end
        end

        // read launch: only for the eeprom, only when idle
        // selects are checked as written and as held, either one refuses
        if (ctl_write && !busy && sfr_wdata[`NV_CTL_RD] && !launch_req) begin
            if (!sfr_wdata[`NV_CTL_MEM] && !sfr_wdata[`NV_CTL_CFG] && eeprom_sel) begin
                d.rd = 1'b1;
            end
        end

        // unlock key tracker; any other write breaks the chain
        // so a stray write between the key bytes forces the whole sequence again
        if (sfr_wr) begin
            if (sfr_sel == `NV_SEL_KEY) begin
                // key bytes only move the tracker, nothing is stored
                if (sfr_wdata == `NV_KEY_FIRST) begin
                    d.key = nv_pkg::KEY_HALF;
                end else if (sfr_wdata == `NV_KEY_SECOND && q.key == nv_pkg::KEY_HALF) begin
                    d.key = nv_pkg::KEY_ARMED;
                end else begin
                    d.key = nv_pkg::KEY_IDLE;
                end
            end else begin
                d.key = nv_pkg::KEY_IDLE;
            end
        end

        // write launch; requests during a running write are dropped
        // a refused launch only raises abort, which software can inspect
        if (launch_req && !busy) begin
            if (q.write_permit && key_armed) begin
                d.wr = 1'b1;
                d.abort = 1'b1;
                d.tmr = 32'h0000_0000;
                // eeprom always erases first; flash only with row erase
                if (erase_first) begin
                    d.st = nv_pkg::ST_ERASE;
                end else begin
                    d.st = nv_pkg::ST_PROG;
                end
            end else begin
                d.abort = 1'b1;
            end
        end

        // self-timed sequencer, timer decides the end
        // the timer starts at zero, so a phase ends at its length minus one
        if (busy) begin
            d.tmr = q.tmr + 32'h0000_0001;
            if (last_tick) begin
                d.tmr = 32'h0000_0000;
                if (q.st == nv_pkg::ST_ERASE && eeprom_sel) begin
                    mem_we = 1'b1;
                    mem_wdata = `NV_ERASED_BYTE;
                    d.st = nv_pkg::ST_PROG;
                end else begin
                    if (q.st == nv_pkg::ST_PROG && eeprom_sel) begin
                        mem_we = 1'b1;
                        mem_wdata = q.data;
                    end
                    if (q.st == nv_pkg::ST_ERASE) begin
                        d.free = 1'b0;
                    end
                    d.st = nv_pkg::ST_IDLE;
                    d.wr = 1'b0;
                    d.abort = 1'b0;
                    d.done_flag = 1'b1;
                end
            end
        end

        // pin or watchdog reset: stop, keep abort evidence and selects
        // address and data survive too, so the cut location can be rewritten
        if (warm_reset) begin
            if (busy) begin
                d.abort = 1'b1;
                d.done_flag = q.done_flag;
            end
            mem_we = 1'b0;
            d.st = nv_pkg::ST_IDLE;
            d.tmr = 32'h0000_0000;
            d.wr = 1'b0;
            d.rd = 1'b0;
            d.write_permit = 1'b0;
            d.free = 1'b0;
            d.key = nv_pkg::KEY_IDLE;
        end

        // interrupt request follows the flag and its enable
        d.irq = d.done_flag && d.done_en;

        // register readback; reserved bits and the key port read zero
        // the answer is registered, so it stands one cycle after the strobe
        d.rdata = 8'h00;
        if (sfr_rd) begin
            if (sfr_sel == `NV_SEL_TP_UPPER) begin
                d.rdata = {2'b00, q.tptr[21:16]};
            end else if (sfr_sel == `NV_SEL_TP_HIGH) begin
                d.rdata = q.tptr[15:8];
            end else if (sfr_sel == `NV_SEL_TP_LOW) begin
                d.rdata = q.tptr[7:0];
            end else if (sfr_sel == `NV_SEL_TLATCH) begin
                d.rdata = q.tlatch;
            end else if (sfr_sel == `NV_SEL_KEY) begin
                d.rdata = 8'h00;
            end else if (sfr_sel == `NV_SEL_CTRL) begin
                d.rdata = {q.sel_mem, q.sel_cfg, 1'b0, q.free,
                    q.abort, q.write_permit, q.wr, q.rd};
            end else if (sfr_sel == `NV_SEL_PRIO2) begin
                d.rdata = {3'b000, q.done_pri, 4'h0};
            end else if (sfr_sel == `NV_SEL_FLAGS2) begin
                d.rdata = {3'b000, q.done_flag, 4'h0};
            end else if (sfr_sel == `NV_SEL_ENAB2) begin
                d.rdata = {3'b000, q.done_en, 4'h0};
            end else if (sfr_sel == `NV_SEL_ADDR_LO) begin
                d.rdata = q.addr_lo;
            end else if (sfr_sel == `NV_SEL_ADDR_HI) begin
                d.rdata = {6'b000000, q.addr_hi};
            end else if (sfr_sel == `NV_SEL_DATA) begin
                d.rdata = q.data;
            end
        end
    end

    // state register; selects and abort are undefined at power-up,
    // cleared here so simulation starts from known values;
    // a pin or watchdog event is not a power-on reset and never reaches here
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            q.sel_mem <= 1'b0;
            q.sel_cfg <= 1'b0;
            q.free <= 1'b0;
            q.abort <= 1'b0;
            q.write_permit <= 1'b0;
            q.wr <= 1'b0;
            q.rd <= 1'b0;
            q.addr_lo <= `NV_RST_BYTE;
            q.addr_hi <= 2'b00;
            q.data <= `NV_RST_BYTE;
            q.tptr <= 22'h000000;
            q.tlatch <= `NV_RST_BYTE;
            q.done_flag <= 1'b0;
            q.done_en <= 1'b0;
            q.done_pri <= 1'b0;
            q.irq <= 1'b0;
            q.key <= nv_pkg::KEY_IDLE;
            q.st <= nv_pkg::ST_IDLE;
            q.tmr <= 32'h0000_0000;
            q.rdata <= `NV_RST_BYTE;
            q.pin_sync <= 3'h0; // pin assumed idle at power-up
            q.pin_lvl <= 1'b0;
        end else begin
            q <= d;
        end
    end

    // outputs straight from state flops
    // target outputs are gated by busy so they rest low between writes
    assign sfr_rdata = q.rdata;
    assign prog_busy = busy;
    assign prog_flash = q.sel_mem && !q.sel_cfg && busy;
    assign prog_cfg = q.sel_cfg && busy;
    assign prog_erase = (q.st == nv_pkg::ST_ERASE);
    assign table_ptr = q.tptr;
    assign table_data = q.tlatch;
    assign done_irq = q.irq;
    assign done_high_prio = q.done_pri;

endmodule

// file: sim/nv_access_sva.sv
`timescale 1ns/1ps
`include "nv_cfg.svh"

module nv_access_sva #(
    parameter int unsigned PROG_CYCLES = 20
) (
    input wire logic clk, // system clock
    input wire logic rstn, // power-on reset
    input wire logic pin_reset, // reset pin event
    input wire logic wdog_reset, // watchdog event
    input wire logic [3:0] sfr_sel, // register select
    input wire logic sfr_wr, // write strobe
    input wire logic sfr_rd, // read strobe
    input wire logic [7:0] sfr_wdata, // write data
    input wire logic [7:0] sfr_rdata, // read data
    input wire logic prog_busy, // self-timed op
    input wire logic prog_flash, // flash target
    input wire logic prog_cfg, // config target
    input wire logic prog_erase, // erase phase
    input wire logic [21:0] table_ptr, // table pointer
    input wire logic [7:0] table_data, // table latch
    input wire logic done_irq, // write-done request
    input wire logic done_high_prio // its priority
);
    logic [31:0] busy_cnt_q;
    logic [31:0] busy_cnt_d;

    // busy length counter; a repetition this long would crawl
    always_comb begin
        busy_cnt_d = prog_busy ? busy_cnt_q + 32'h1 : 32'h0;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            busy_cnt_q <= 32'h0;
        end else begin
            busy_cnt_q <= busy_cnt_d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // steps of a launch and of a cut-short write
    sequence s_launch_wr;
        sfr_wr && sfr_sel == `NV_SEL_CTRL && sfr_wdata[`NV_CTL_WR];
    endsequence
    sequence s_cut;
        prog_busy && wdog_reset;
    endsequence
    sequence s_pin_held;
        pin_reset [*3];
    endsequence

    AST_KEY_READ: assert property (sfr_rd && sfr_sel == `NV_SEL_KEY |=> sfr_rdata == 8'h00)
        else $error("key port read not zero");
    AST_BUSY_LEN: assert property ($fell(prog_busy) && !$past(pin_reset) && !$past(wdog_reset)
        |-> busy_cnt_q == PROG_CYCLES)
        else $error("self-timed length wrong");
    AST_EE_ERASE_FIRST: assert property ($rose(prog_busy) && !prog_flash && !prog_cfg
        |-> prog_erase)
        else $error("eeprom write did not erase first");
    AST_CUT_ENDS: assert property (s_cut |=> !prog_busy && !prog_erase)
        else $error("reset did not stop the write");
    AST_PIN_CUT_ENDS: assert property (s_pin_held |-> ##2 (!prog_busy && !prog_erase))
        else $error("pin reset did not stop the write");
    AST_LAUNCH_CAUSE: assert property ($rose(prog_busy) |-> $past(sfr_wr)
        && $past(sfr_sel) == `NV_SEL_CTRL && $past(sfr_wdata[`NV_CTL_WR]))
        else $error("write started without a launch");
    AST_TP_UPPER: assert property (sfr_wr && sfr_sel == `NV_SEL_TP_UPPER
        |=> table_ptr[21:16] == $past(sfr_wdata[5:0]))
        else $error("table pointer upper wrong");
    AST_FLASH_ERASE_ENDS: assert property ($fell(prog_erase) && $past(prog_flash)
        |-> !prog_busy)
        else $error("flash erase did not end the operation");
    AST_TARGET_STABLE: assert property (prog_busy && $past(prog_busy)
        |-> $stable(prog_flash) && $stable(prog_cfg))
        else $error("target changed while busy");

    COV_LAUNCH: cover property (s_launch_wr ##1 $rose(prog_busy));
endmodule

bind nv_memory_access_control nv_access_sva #(.PROG_CYCLES(PROG_CYCLES)) u_sva (
    .clk(clk), .rstn(rstn), .pin_reset(pin_reset), .wdog_reset(wdog_reset),
    .sfr_sel(sfr_sel), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .prog_busy(prog_busy), .prog_flash(prog_flash),
    .prog_cfg(prog_cfg), .prog_erase(prog_erase), .table_ptr(table_ptr),
    .table_data(table_data), .done_irq(done_irq), .done_high_prio(done_high_prio)
);

// file: sim/cpu_sfr_model.sv
`timescale 1ns/1ps
`include "nv_cfg.svh"

module cpu_sfr_model (
    input wire logic clk, // system clock
    input wire logic [7:0] sfr_rdata, // read data
    output logic [3:0] sfr_sel, // register select
    output logic sfr_wr, // write strobe
    output logic sfr_rd, // read strobe
    output logic [7:0] sfr_wdata // write data
);
    // idle bus at time zero
    initial begin
        sfr_sel = 4'h0;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        sfr_wdata = 8'h00;
    end

    // released lines show the inverse so a stale value cannot pass
    task automatic free_bus();
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        sfr_sel = ~sfr_sel;
        sfr_wdata = ~sfr_wdata;
    endtask

    // one access per two cycles, so a strobe never toggles twice at once
    task automatic put(input logic [3:0] sel, input logic [7:0] data);
        @(posedge clk);
        #1;
        sfr_sel = sel;
        sfr_wdata = data;
        sfr_wr = 1'b1;
        @(posedge clk);
        #1;
        free_bus();
    endtask

    task automatic get(input logic [3:0] sel, output logic [7:0] data);
        @(posedge clk);
        #1;
        sfr_sel = sel;
        sfr_rd = 1'b1;
        @(posedge clk);
        #1;
        data = sfr_rdata;
        free_bus();
    endtask

    // key bytes then the launching control write, nothing between
    task automatic launch(input logic [7:0] ctrl);
        put(`NV_SEL_KEY, `NV_KEY_FIRST);
        put(`NV_SEL_KEY, `NV_KEY_SECOND);
        put(`NV_SEL_CTRL, ctrl);
    endtask
endmodule

// file: sim/test_nv_memory_access_control.sv
`timescale 1ns/1ps
`include "nv_cfg.svh"

module test_nv_memory_access_control;
    localparam int unsigned PROG = 20;
    logic clk, rstn, pin_reset, wdog_reset, sfr_wr, sfr_rd;
    logic [3:0] sfr_sel;
    logic [7:0] sfr_wdata, sfr_rdata, table_data, v, s;
    logic prog_busy, prog_flash, prog_cfg, prog_erase, done_irq, done_high_prio;
    logic [21:0] table_ptr;
    int n_errors;
    int n_compared;

    cpu_sfr_model cpu (.clk(clk), .sfr_rdata(sfr_rdata), .sfr_sel(sfr_sel),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata));

    nv_memory_access_control #(.PROG_CYCLES(PROG)) dut (.clk(clk), .rstn(rstn),
        .pin_reset(pin_reset), .wdog_reset(wdog_reset), .sfr_sel(sfr_sel),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .prog_busy(prog_busy), .prog_flash(prog_flash), .prog_cfg(prog_cfg),
        .prog_erase(prog_erase), .table_ptr(table_ptr), .table_data(table_data),
        .done_irq(done_irq), .done_high_prio(done_high_prio));

    // free-running clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic give_verdict();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [21:0] seen, input logic [21:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic rdchk(input logic [3:0] sel, input logic [7:0] exp);
        cpu.get(sel, v);
        chk(v, exp);
    endtask

    // bounded wait for the self-timed operation
    task automatic wait_idle();
        for (int k = 0; k < 200; k++) begin
            if (prog_busy === 1'b0) return;
            @(posedge clk);
            #1;
        end
        n_errors++;
        give_verdict();
    endtask

    initial begin
        rstn = 1'b0;
        pin_reset = 1'b0;
        wdog_reset = 1'b0;
        n_errors = 0;
        n_compared = 0;
        repeat (4) @(posedge clk);
        #1;
        rstn = 1'b1;
        rdchk(`NV_SEL_CTRL, 8'h00);
        rdchk(`NV_SEL_KEY, 8'h00);
        cpu.put(`NV_SEL_CTRL, 8'h20);
        rdchk(`NV_SEL_CTRL, 8'h00);
        // eeprom byte write, with writes attempted while busy
        cpu.put(`NV_SEL_ADDR_LO, 8'h3c);
        cpu.put(`NV_SEL_ADDR_HI, 8'hff);
        rdchk(`NV_SEL_ADDR_HI, 8'h03);
        cpu.put(`NV_SEL_DATA, 8'ha5);
        cpu.put(`NV_SEL_ENAB2, 8'h10);
        cpu.put(`NV_SEL_PRIO2, 8'h10);
        cpu.put(`NV_SEL_CTRL, 8'h04);
        cpu.launch(8'h06);
        chk(prog_erase, 1'b1);
        rdchk(`NV_SEL_CTRL, 8'h0e);
        cpu.put(`NV_SEL_ADDR_LO, 8'h00);
        cpu.put(`NV_SEL_CTRL, 8'hc4);
        cpu.put(`NV_SEL_DATA, 8'h00);
        wait_idle();
        rdchk(`NV_SEL_CTRL, 8'h04);
        rdchk(`NV_SEL_ADDR_LO, 8'h3c);
        rdchk(`NV_SEL_FLAGS2, 8'h10);
        chk({done_irq, done_high_prio}, 2'b11);
        cpu.put(`NV_SEL_FLAGS2, 8'h00);
        rdchk(`NV_SEL_FLAGS2, 8'h00);
        // read back over a clobbered data register
        cpu.put(`NV_SEL_DATA, 8'h00);
        cpu.put(`NV_SEL_CTRL, 8'h05);
        rdchk(`NV_SEL_CTRL, 8'h04);
        rdchk(`NV_SEL_DATA, 8'ha5);
        // improper launches: no permit, no key, permit in same write
        cpu.put(`NV_SEL_CTRL, 8'h00);
        cpu.put(`NV_SEL_CTRL, 8'h02);
        chk(prog_busy, 1'b0);
        rdchk(`NV_SEL_CTRL, 8'h08);
        cpu.put(`NV_SEL_CTRL, 8'h04);
        cpu.put(`NV_SEL_CTRL, 8'h06);
        chk(prog_busy, 1'b0);
        cpu.put(`NV_SEL_CTRL, 8'h00);
        cpu.launch(8'h06);
        chk(prog_busy, 1'b0);
        // read launch refused with either select set
        for (int i = 0; i < 2; i++) begin
            s = (i == 0) ? 8'h80 : 8'h40;
            cpu.put(`NV_SEL_CTRL, s);
            cpu.put(`NV_SEL_CTRL, s | 8'h01);
            rdchk(`NV_SEL_CTRL, s);
        end
        // flash row erase
        cpu.put(`NV_SEL_TP_UPPER, 8'hff);
        chk(table_ptr[21:16], 6'h3f);
        cpu.put(`NV_SEL_TP_HIGH, 8'h5a);
        cpu.put(`NV_SEL_TP_LOW, 8'hc3);
        cpu.put(`NV_SEL_TLATCH, 8'h96);
        chk(table_ptr, 22'h3f5ac3);
        chk(table_data, 8'h96);
        cpu.put(`NV_SEL_CTRL, 8'h94);
        cpu.launch(8'h96);
        chk({prog_flash, prog_erase}, 2'b11);
        wait_idle();
        rdchk(`NV_SEL_CTRL, 8'h84);
        // config write cut short by each reset source
        for (int i = 0; i < 2; i++) begin
            cpu.put(`NV_SEL_FLAGS2, 8'h00);
            cpu.put(`NV_SEL_CTRL, 8'h44);
            cpu.launch(8'h46);
            chk(prog_cfg, 1'b1);
            if (i == 0) pin_reset = 1'b1;
            else wdog_reset = 1'b1;
            // the pin passes a three-flop filter, so hold it long enough to count
            repeat (4) @(posedge clk);
            #1;
            pin_reset = 1'b0;
            wdog_reset = 1'b0;
            chk(prog_busy, 1'b0);
            rdchk(`NV_SEL_CTRL, 8'h48);
            rdchk(`NV_SEL_FLAGS2, 8'h00);
        end
        give_verdict();
    end
endmodule
